// ==== shared/rhl_pkg.sv ====
// package for the reverse high-speed lane clocking block
// assumes a 10 MHz core clock and a separate link bit clock
package rhl_pkg;

  // ----------------------------------------------------------------
  // core clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CORE_CLK_KHZ    = 10000;
  // time between two steps of the spread triangle, in ns
  localparam int unsigned SSC_STEP_NS     = 1000;
  localparam int unsigned SSC_STEP_CYC    =
    (SSC_STEP_NS * CORE_CLK_KHZ) / 1000000;
  localparam int unsigned SSC_CNT_W       = 8;

  // ----------------------------------------------------------------
  // spread-spectrum triangle
  // ----------------------------------------------------------------
  localparam logic [7:0] SSC_DEV_MAX      = 8'h3F;
  localparam logic [7:0] SSC_DEV_ZERO     = 8'h00;

  // ----------------------------------------------------------------
  // reverse receive
  // ----------------------------------------------------------------
  // last of the link clock cycles per reverse bit (two ddr periods)
  localparam logic [1:0] REV_PH_LAST      = 2'h3;
  // sample half a reverse bit after the observed edge
  localparam logic [1:0] REV_PH_OFFSET    = 2'h2;
  localparam logic [7:0] SYNC_WORD        = 8'h1D;
  localparam logic [2:0] BYTE_BIT_LAST    = 3'h7;
  localparam logic [1:0] RATE_RESET       = 2'h0;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_LP,
    ST_FWD_HS,
    ST_ESC,
    ST_TURN,
    ST_REV_HS
  } rhl_mode_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } rhl_rev_byte_type;

  localparam rhl_rev_byte_type REV_BYTE_RESET = '{valid: 1'b0,
                                                  data:  8'h00};

endpackage

// ==== rtl/rhl_lane_master.sv ====
// master end of one lane: clock lane drive, reverse receive, spread ctl
// assumes turnaround handshakes come from logic on the core clock and
// the reverse data pin and link clock arrive from outside its domain
`timescale 1ns/1ps

// What this block does
// - reverse high-speed only after completed turnaround
// - master keeps clock lane during reverse
// - sampling phase chosen from sync transitions
// - reverse sampling tolerates instantaneous interval variation
// - clock rate changes only with lanes low-power
// - integrator can enable or disable spreading
// - spreading stays constant through high-speed mode
// - spreading kept off in escape mode
// - one spread profile shared by all lanes
// - spread supported above 2.5 Gbps rates
// - triangular spread profile as baseline
// - forward ddr clock toggles once per bit
module rhl_lane_master (
  input  wire logic                      i_core_clk,
  input  wire logic                      i_rst_n,
  input  wire logic                      i_link_clk,
  input  wire logic                      i_hs_req,
  input  wire logic                      i_esc_req,
  input  wire logic                      i_turn_req,
  input  wire logic                      i_turn_done,
  input  wire logic                      i_burst_end,
  input  wire logic                      i_ssc_enable,
  input  wire logic                      i_rate_change_req,
  input  wire logic [1:0]                i_rate_sel,
  input  wire logic                      i_lanes_lp,
  input  wire logic                      i_rev_data,
  output rhl_pkg::rhl_mode_type          o_mode,
  output logic                           o_clk_lane_oe,
  output logic                           o_data_lane_oe,
  output logic                           o_hs_clk,
  output rhl_pkg::rhl_rev_byte_type      o_rev_byte,
  output logic                           o_rev_locked,
  output logic [7:0]                     o_ssc_offset,
  output logic                           o_ssc_active,
  output logic [1:0]                     o_rate_sel,
  output logic                           o_rate_ack
);
  import rhl_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  rhl_mode_type        state_reg;
  rhl_mode_type        state_next;
  logic                ssc_active_reg;
  logic [7:0]          ssc_offset_reg;
  logic                ssc_down_reg;
  logic [SSC_CNT_W-1:0] ssc_cnt_reg;
  logic                clk_run_reg;
  logic                rev_en_reg;
  logic                tog_s1_reg;
  logic                tog_s2_reg;
  logic                tog_s3_reg;
  logic                lock_s1_reg;
  logic                lock_s2_reg;
  // link domain
  logic                run_s1_reg;
  logic                run_s2_reg;
  logic                ren_s1_reg;
  logic                ren_s2_reg;
  logic                rd_s1_reg;
  logic                rd_s2_reg;
  logic                rd_prev_reg;
  logic [1:0]          ph_reg;
  logic [1:0]          samp_ph_reg;
  logic                locked_reg;
  logic                aligned_reg;
  logic [7:0]          shift_reg;
  logic [2:0]          bit_cnt_reg;
  logic [7:0]          byte_reg;
  logic                tog_reg;
  logic                hs_clk_reg;
  logic                samp_now;
  logic [7:0]          shift_next;

  // ----------------------------------------------------------------
  // lane mode
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_LP: begin
        if (i_hs_req) begin
          state_next = ST_FWD_HS;
        end else if (i_turn_req) begin
          state_next = ST_TURN;
        end else if (i_esc_req) begin
          state_next = ST_ESC;
        end
      end
      ST_TURN: begin
        if (i_turn_done) begin
          state_next = ST_REV_HS;
        end
      end
      ST_FWD_HS, ST_ESC, ST_REV_HS: begin
        if (i_burst_end) begin
          state_next = ST_LP;
        end
      end
      default: begin
        state_next = ST_LP;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= ST_LP;
    end else begin
      state_reg <= state_next;
    end
  end

  // clock lane stays driven in reverse
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_mode         <= ST_LP;
      o_clk_lane_oe  <= 1'b0;
      o_data_lane_oe <= 1'b0;
      clk_run_reg    <= 1'b0;
      rev_en_reg     <= 1'b0;
    end else begin
      o_mode         <= state_reg;
      o_clk_lane_oe  <= (state_reg == ST_FWD_HS) ||
                        (state_reg == ST_TURN) ||
                        (state_reg == ST_REV_HS);
      o_data_lane_oe <= (state_reg == ST_FWD_HS);
      clk_run_reg    <= (state_reg == ST_FWD_HS) ||
                        (state_reg == ST_TURN) ||
                        (state_reg == ST_REV_HS);
      rev_en_reg     <= (state_reg == ST_REV_HS);
    end
  end

  // ----------------------------------------------------------------
  // clock rate select
  // ----------------------------------------------------------------
  // rate changes only between bursts
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rate_sel <= RATE_RESET;
      o_rate_ack <= 1'b0;
    end else begin
      o_rate_ack <= 1'b0;
      if (i_rate_change_req && i_lanes_lp && state_reg == ST_LP) begin
        o_rate_sel <= i_rate_sel;
        o_rate_ack <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // spread-spectrum control
  // ----------------------------------------------------------------
  // enable taken when leaving LP for forward high-speed or turnaround
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ssc_active_reg <= 1'b0;
    end else if (state_reg == ST_LP && (state_next == ST_FWD_HS ||
                                         state_next == ST_TURN)) begin
      ssc_active_reg <= i_ssc_enable;
    end else if (state_next == ST_LP || state_next == ST_ESC) begin
      ssc_active_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ssc_cnt_reg    <= '0;
      ssc_offset_reg <= SSC_DEV_ZERO;
      ssc_down_reg   <= 1'b0;
    end else if (!ssc_active_reg) begin
      ssc_cnt_reg    <= '0;
      ssc_offset_reg <= SSC_DEV_ZERO;
      ssc_down_reg   <= 1'b0;
    end else if (ssc_cnt_reg ==
                 SSC_CNT_W'(SSC_STEP_CYC - 1)) begin
      ssc_cnt_reg <= '0;
      if (ssc_down_reg) begin
        ssc_offset_reg <= ssc_offset_reg - 8'h01;
        if (ssc_offset_reg == 8'h01) begin
          ssc_down_reg <= 1'b0;
        end
      end else begin
        ssc_offset_reg <= ssc_offset_reg + 8'h01;
        if (ssc_offset_reg == SSC_DEV_MAX - 8'h01) begin
          ssc_down_reg <= 1'b1;
        end
      end
    end else begin
      ssc_cnt_reg <= ssc_cnt_reg + SSC_CNT_W'(1);
    end
  end

  // one offset feeds clock and data lanes
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ssc_offset <= SSC_DEV_ZERO;
      o_ssc_active <= 1'b0;
    end else begin
      o_ssc_offset <= ssc_offset_reg;
      o_ssc_active <= ssc_active_reg;
    end
  end

  // ----------------------------------------------------------------
  // link domain: forward ddr clock
  // ----------------------------------------------------------------
  always_ff @(posedge i_link_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      run_s1_reg <= 1'b0;
      run_s2_reg <= 1'b0;
      ren_s1_reg <= 1'b0;
      ren_s2_reg <= 1'b0;
      rd_s1_reg  <= 1'b0;
      rd_s2_reg  <= 1'b0;
    end else begin
      run_s1_reg <= clk_run_reg;
      run_s2_reg <= run_s1_reg;
      ren_s1_reg <= rev_en_reg;
      ren_s2_reg <= ren_s1_reg;
      rd_s1_reg  <= i_rev_data;
      rd_s2_reg  <= rd_s1_reg;
    end
  end

  // one clock transition per bit time
  always_ff @(posedge i_link_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hs_clk_reg <= 1'b0;
    end else if (run_s2_reg) begin
      hs_clk_reg <= ~hs_clk_reg;
    end else begin
      hs_clk_reg <= 1'b0;
    end
  end

  assign o_hs_clk = hs_clk_reg;

  // ----------------------------------------------------------------
  // link domain: reverse phase search and sampling
  // ----------------------------------------------------------------
  // four link cycles per reverse bit
  always_ff @(posedge i_link_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ph_reg      <= 2'h0;
      rd_prev_reg <= 1'b0;
    end else begin
      ph_reg      <= (ph_reg == REV_PH_LAST) ? 2'h0 : ph_reg + 2'h1;
      rd_prev_reg <= rd_s2_reg;
    end
  end

  // launch phase assumed fixed per burst
  always_ff @(posedge i_link_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      locked_reg  <= 1'b0;
      samp_ph_reg <= 2'h0;
    end else if (!ren_s2_reg) begin
      locked_reg  <= 1'b0;
    end else if (!locked_reg && rd_s2_reg != rd_prev_reg) begin
      locked_reg  <= 1'b1;
      samp_ph_reg <= ph_reg + REV_PH_OFFSET;
    end
  end

  assign samp_now   = locked_reg && ren_s2_reg && ph_reg == samp_ph_reg;
  assign shift_next = {rd_s2_reg, shift_reg[7:1]};

  // byte framing starts on sync word
  always_ff @(posedge i_link_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      shift_reg   <= 8'h00;
      aligned_reg <= 1'b0;
      bit_cnt_reg <= 3'h0;
      byte_reg    <= 8'h00;
      tog_reg     <= 1'b0;
    end else if (!ren_s2_reg) begin
      shift_reg   <= 8'h00;
      aligned_reg <= 1'b0;
      bit_cnt_reg <= 3'h0;
    end else if (samp_now) begin
      shift_reg <= shift_next;
      if (!aligned_reg) begin
        if (shift_next == SYNC_WORD) begin
          aligned_reg <= 1'b1;
          bit_cnt_reg <= 3'h0;
        end
      end else if (bit_cnt_reg == BYTE_BIT_LAST) begin
        bit_cnt_reg <= 3'h0;
        byte_reg    <= shift_next;
        tog_reg     <= ~tog_reg;
      end else begin
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // crossing back to the core clock
  // ----------------------------------------------------------------
  // byte_reg is stable for a whole byte time after each toggle
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tog_s1_reg   <= 1'b0;
      tog_s2_reg   <= 1'b0;
      tog_s3_reg   <= 1'b0;
      lock_s1_reg  <= 1'b0;
      lock_s2_reg  <= 1'b0;
      o_rev_locked <= 1'b0;
      o_rev_byte   <= REV_BYTE_RESET;
    end else begin
      tog_s1_reg   <= tog_reg;
      tog_s2_reg   <= tog_s1_reg;
      tog_s3_reg   <= tog_s2_reg;
      lock_s1_reg  <= aligned_reg;
      lock_s2_reg  <= lock_s1_reg;
      o_rev_locked <= lock_s2_reg;
      o_rev_byte.valid <= tog_s2_reg ^ tog_s3_reg;
      if (tog_s2_reg ^ tog_s3_reg) begin
        o_rev_byte.data <= byte_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks, core domain
  // ----------------------------------------------------------------
  chk_rev_after_turn: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (state_reg == ST_REV_HS && $past(state_reg) != ST_REV_HS) |->
      ($past(state_reg) == ST_TURN && $past(i_turn_done)))
    else $error("reverse mode entered without turnaround");

  chk_rev_clk_lane: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (state_reg == ST_REV_HS) |=> (o_clk_lane_oe && !o_data_lane_oe))
    else $error("clock lane not driven during reverse");

  chk_rate_hold: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (o_rate_sel != $past(o_rate_sel)) |->
      ($past(i_lanes_lp) && $past(state_reg) == ST_LP && o_rate_ack))
    else $error("rate changed outside low-power");

  chk_ssc_steady: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (state_reg == ST_FWD_HS && $past(state_reg) == ST_FWD_HS) |->
      $stable(ssc_active_reg))
    else $error("spreading toggled inside high-speed mode");

  chk_ssc_escape: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (state_reg == ST_ESC) |-> ##2 (!o_ssc_active ||
                                   $past(state_reg, 2) != ST_ESC))
    else $error("spreading active in escape mode");

  chk_ssc_enable: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (state_reg == ST_LP && state_next == ST_FWD_HS) |=>
      (ssc_active_reg == $past(i_ssc_enable)))
    else $error("spread enable not taken at entry");

  chk_ssc_range: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (ssc_offset_reg != $past(ssc_offset_reg)) |->
      (ssc_offset_reg <= SSC_DEV_MAX &&
       (ssc_offset_reg == $past(ssc_offset_reg) + 8'h01 ||
        ssc_offset_reg == $past(ssc_offset_reg) - 8'h01 ||
        ssc_offset_reg == SSC_DEV_ZERO)))
    else $error("spread offset left triangle");

  // ----------------------------------------------------------------
  // checks, link domain
  // ----------------------------------------------------------------
  chk_ddr_toggle: assert property (
    @(posedge i_link_clk) disable iff (!i_rst_n)
    (run_s2_reg && $past(run_s2_reg)) |-> (hs_clk_reg != $past(hs_clk_reg)))
    else $error("ddr clock missed a transition");

  chk_phase_hold: assert property (
    @(posedge i_link_clk) disable iff (!i_rst_n)
    (locked_reg && ren_s2_reg) |=> (!locked_reg || $stable(samp_ph_reg)))
    else $error("sampling phase moved inside burst");

  chk_phase_pick: assert property (
    @(posedge i_link_clk) disable iff (!i_rst_n)
    (ren_s2_reg && !locked_reg && rd_s2_reg != rd_prev_reg) |=>
      (locked_reg && samp_ph_reg == $past(ph_reg) + REV_PH_OFFSET))
    else $error("phase not taken from sync edge");

  chk_bit_period: assert property (
    @(posedge i_link_clk) disable iff (!i_rst_n)
    samp_now |=> !samp_now [*3])
    else $error("reverse bit sampled faster than four cycles");

endmodule

// ==== verification/rhl_slave_model.sv ====
// slave end of the lane: sends one reverse burst when asked
// assumes it is clocked by the forwarded ddr clock of the master
`timescale 1ns/1ps
module rhl_slave_model
  import rhl_pkg::*;
(
  input  wire logic        i_fwd_clk,
  input  wire logic        i_go,
  input  wire logic [1:0]  i_phase,
  input  wire logic [15:0] i_payload,
  output logic             o_data,
  output logic             o_busy
);
  // ----------------------------------------------------------------
  // burst sender
  // ----------------------------------------------------------------
  logic [27:0] frame_reg;
  logic [7:0]  cnt_reg;
  logic [7:0]  idx;
  logic [1:0]  ph_reg;
  logic        done_reg;

  initial begin
    o_data = 1'b0;
    o_busy = 1'b0;
    done_reg = 1'b0;
    cnt_reg = 8'h00;
    ph_reg = 2'h0;
    frame_reg = '0;
  end

  assign idx = (cnt_reg - {6'h00, ph_reg}) >> 2;

  // burst starts when i_go is high, four zero bits then sync
  // one bit per four ddr edges, phase held per burst
  always @(posedge i_fwd_clk or negedge i_fwd_clk) begin
    if (!i_go) begin
      done_reg <= 1'b0;
      o_data <= ~o_data;
    end else if (!o_busy && !done_reg) begin
      o_busy <= 1'b1;
      cnt_reg <= 8'h00;
      ph_reg <= i_phase;
      frame_reg <= {i_payload, SYNC_WORD, 4'h0};
      o_data <= 1'b0;
    end else if (o_busy) begin
      cnt_reg <= cnt_reg + 8'h01;
      if (cnt_reg < {6'h00, ph_reg}) begin
        o_data <= 1'b0;
      end else if (idx < 8'h1C) begin
        o_data <= frame_reg[idx[4:0]];
      end else begin
        o_busy <= 1'b0;
        done_reg <= 1'b1;
        o_data <= ~frame_reg[27];
      end
    end
  end
endmodule

// ==== verification/rhl_lane_master_tb_top.sv ====
// self-checking bench for the lane master
// assumes the package, the design and the slave model are compiled first
`timescale 1ns/1ps
module rhl_lane_master_tb_top;
  import rhl_pkg::*;
  logic i_core_clk, i_rst_n, i_link_clk, i_hs_req, i_esc_req, i_turn_req;
  logic i_turn_done, i_burst_end, i_ssc_enable, i_rate_change_req;
  logic i_lanes_lp, i_rev_data, o_clk_lane_oe, o_data_lane_oe, o_hs_clk;
  logic o_rev_locked, o_ssc_active, o_rate_ack, go, busy, hs_a;
  logic [1:0]       i_rate_sel, o_rate_sel, phase;
  logic [7:0]       o_ssc_offset, r, r2;
  logic [7:0]       lfsr_reg = 8'h28;
  logic [8:0]       e;
  logic [15:0]      payload;
  rhl_mode_type     o_mode;
  rhl_rev_byte_type o_rev_byte;
  logic [7:0]       byte_q[$];
  logic [1:0]       rate_q[$];
  int               err_total = 0;
  int               n_checks = 0;

  rhl_lane_master DUT (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .i_link_clk(i_link_clk), .i_hs_req(i_hs_req), .i_esc_req(i_esc_req),
    .i_turn_req(i_turn_req), .i_turn_done(i_turn_done),
    .i_burst_end(i_burst_end), .i_ssc_enable(i_ssc_enable),
    .i_rate_change_req(i_rate_change_req), .i_rate_sel(i_rate_sel),
    .i_lanes_lp(i_lanes_lp), .i_rev_data(i_rev_data), .o_mode(o_mode),
    .o_clk_lane_oe(o_clk_lane_oe), .o_data_lane_oe(o_data_lane_oe),
    .o_hs_clk(o_hs_clk), .o_rev_byte(o_rev_byte),
    .o_rev_locked(o_rev_locked), .o_ssc_offset(o_ssc_offset),
    .o_ssc_active(o_ssc_active), .o_rate_sel(o_rate_sel),
    .o_rate_ack(o_rate_ack));

  rhl_slave_model slave (.i_fwd_clk(o_hs_clk), .i_go(go), .i_phase(phase),
    .i_payload(payload), .o_data(i_rev_data), .o_busy(busy));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] nxt();
    lfsr_reg = {lfsr_reg[6:0],
                lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
    return lfsr_reg;
  endfunction

  task automatic wrap_up();
    if (err_total == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic cmp_val(string what, logic [8:0] exp, logic [8:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmp_mode(rhl_mode_type m);
    n_checks++;
    if (o_mode !== m) begin
      err_total++;
      $display("unexpected mode: expected %h seen %h", m, o_mode);
    end
  endtask

  task automatic cyc(int n);
    repeat (n) @(negedge i_core_clk);
  endtask

  task automatic wait_mode(rhl_mode_type m);
    for (int i = 0; i < 12 && o_mode !== m; i++) cyc(1);
    cmp_mode(m);
  endtask

  task automatic wait_busy(logic b);
    for (int i = 0; i < 400 && busy !== b; i++) cyc(1);
    cmp_val("slave busy", 9'(b), 9'(busy));
  endtask

  task automatic pulse_end();
    i_burst_end = 1'b1;
    cyc(1);
    i_burst_end = 1'b0;
    wait_mode(ST_LP);
  endtask

  // ----------------------------------------------------------------
  // clocks, watchdog, result monitor
  // ----------------------------------------------------------------
  initial begin
    i_core_clk = 1'b0;
    forever #50 i_core_clk = ~i_core_clk;
  end

  // jittered link clock, half period 56..68 ns
  initial begin
    i_link_clk = 1'b0;
    #17;
    forever #(56 + (nxt() % 13)) i_link_clk = ~i_link_clk;
  end

  initial begin
    repeat (20000) @(posedge i_core_clk);
    err_total++;
    wrap_up();
  end

  always @(posedge i_core_clk) begin
    #1;
    if (o_rev_byte.valid === 1'b1) begin
      e = byte_q.size() ? {1'b0, byte_q.pop_front()} : 9'h100;
      cmp_val("rev byte", e, {1'b0, o_rev_byte.data});
    end
    if (o_rate_ack === 1'b1) begin
      e = rate_q.size() ? 9'(rate_q.pop_front()) : 9'h100;
      cmp_val("rate sel", e, 9'(o_rate_sel));
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {i_hs_req, i_esc_req, i_turn_req, i_turn_done, i_burst_end} = '0;
    {i_ssc_enable, i_rate_change_req, go} = '0;
    i_rate_sel = 2'h0;
    i_lanes_lp = 1'b0;
    phase = 2'h0;
    payload = 16'h0000;
    i_rst_n = 1'b0;
    repeat (6) @(negedge i_core_clk);
    i_rst_n = 1'b1;
    cmp_mode(ST_LP);
    r = nxt();
    i_rate_sel = r[1:0];
    i_rate_change_req = 1'b1;
    cyc(3);
    rate_q.push_back(r[1:0]);
    i_lanes_lp = 1'b1;
    cyc(1);
    i_rate_change_req = 1'b0;
    cyc(2);
    cmp_val("rate held", 9'(r[1:0]), 9'(o_rate_sel));
    i_ssc_enable = 1'b1;
    i_hs_req = 1'b1;
    cyc(1);
    i_hs_req = 1'b0;
    wait_mode(ST_FWD_HS);
    i_ssc_enable = 1'b0;
    i_rate_change_req = 1'b1;
    cyc(30);
    i_rate_change_req = 1'b0;
    cmp_val("ssc on", 9'h001, 9'(o_ssc_active));
    cmp_val("ssc step", 9'h001, 9'(o_ssc_offset != 8'h00 &&
            o_ssc_offset <= SSC_DEV_MAX));
    @(posedge i_link_clk);
    #1 hs_a = o_hs_clk;
    @(posedge i_link_clk);
    #1 cmp_val("hs clk", 9'(!hs_a), 9'(o_hs_clk));
    cyc(1);
    pulse_end();
    i_ssc_enable = 1'b1;
    i_esc_req = 1'b1;
    cyc(1);
    i_esc_req = 1'b0;
    wait_mode(ST_ESC);
    cyc(15);
    cmp_val("esc ssc", 9'h000, {o_ssc_active, o_ssc_offset});
    pulse_end();
    i_turn_done = 1'b1;
    cyc(1);
    i_turn_done = 1'b0;
    cyc(3);
    cmp_mode(ST_LP);
    for (int p = 0; p < 4; p++) begin
      r = nxt();
      r2 = nxt();
      payload = {r, r2};
      phase = p[1:0];
      i_ssc_enable = p[0];
      i_turn_req = 1'b1;
      cyc(1);
      i_turn_req = 1'b0;
      wait_mode(ST_TURN);
      cmp_val("turn clk oe", 9'h001, 9'(o_clk_lane_oe));
      byte_q.push_back(r2);
      byte_q.push_back(r);
      go = 1'b1;
      i_turn_done = 1'b1;
      cyc(1);
      i_turn_done = 1'b0;
      wait_mode(ST_REV_HS);
      cyc(1);
      cmp_val("rev oe", 9'h002,
              9'({o_clk_lane_oe, o_data_lane_oe}));
      wait_busy(1'b1);
      wait_busy(1'b0);
      cyc(8);
      cmp_val("locked", 9'h001, 9'(o_rev_locked));
      cmp_val("rev ssc", 9'(p[0]), 9'(o_ssc_active));
      cmp_val("bytes left", 9'h000, 9'(byte_q.size()));
      pulse_end();
      go = 1'b0;
      // lock clears through link sync, link edge and core sync
      cyc(10);
      cmp_val("unlocked", 9'h000, 9'(o_rev_locked));
    end
    wrap_up();
  end
endmodule
